// File: psa_pkg.sv
// Package: opcodes, operand selects and constants for the packed SIMD ALU
package psa_pkg;
   typedef enum logic [5:0] {
      move_32, move_64,
      add_wrap_byte, add_wrap_word, add_wrap_dword,
      sub_wrap_byte, sub_wrap_word, sub_wrap_dword,
      add_sat_signed_byte, add_sat_signed_word, sub_sat_signed_byte, sub_sat_signed_word,
      add_sat_unsigned_byte, add_sat_unsigned_word,
      sub_sat_unsigned_byte, sub_sat_unsigned_word,
      mul_word_high_half, mul_word_low_half, mul_add_word_pairs,
      cmp_equal_byte, cmp_equal_word, cmp_equal_dword,
      cmp_greater_byte, cmp_greater_word, cmp_greater_dword,
      pack_word_to_byte_signed, pack_dword_to_word_signed, pack_word_to_byte_unsigned,
      unpack_high_byte, unpack_high_word, unpack_high_dword,
      unpack_low_byte, unpack_low_word, unpack_low_dword,
      bitwise_and_64, bitwise_and_not_64, bitwise_or_64, bitwise_xor_64,
      shl_logical_word, shl_logical_dword, shl_logical_qword,
      shr_logical_word, shr_logical_dword, shr_logical_qword,
      shr_arith_word, shr_arith_dword,
      empty_packed_state
   } psa_op_t;
   typedef enum logic [1:0] {src_packed, src_general, src_memory} psa_src_t;
   localparam int NUM_REGS = 8;
   localparam logic [63:0] REG_RST = 64'h0000_0000_0000_0000;
   localparam logic [15:0] EXP_RST = 16'h0000;
   localparam logic [15:0] EXP_ONES = 16'hFFFF;
   localparam logic [15:0] TAG_VALID = 16'h0000;
   localparam logic [15:0] TAG_EMPTY = 16'hFFFF;
   localparam logic [2:0] LANE_BYTE = 3'h1;
   localparam logic [2:0] LANE_WORD = 3'h2;
   localparam logic [2:0] LANE_DWORD = 3'h4;
   localparam logic [1:0] W_BYTE = 2'h0;
   localparam logic [1:0] W_WORD = 2'h1;
   localparam logic [1:0] W_DWORD = 2'h2;
   localparam logic [1:0] W_QWORD = 2'h3;
   localparam logic signed [33:0] SB_MAX = 34'sh0_0000_007F;
   localparam logic signed [33:0] SB_MIN = 34'sh3_FFFF_FF80;
   localparam logic signed [33:0] SW_MAX = 34'sh0_0000_7FFF;
   localparam logic signed [33:0] SW_MIN = 34'sh3_FFFF_8000;
   localparam logic signed [33:0] UB_MAX = 34'sh0_0000_00FF;
   localparam logic signed [33:0] UW_MAX = 34'sh0_0000_FFFF;
   localparam logic signed [33:0] U_MIN = 34'sh0_0000_0000;
   localparam logic [6:0] SHIFT_LIMIT = 7'h40;
   localparam int HALF_BITS = 32;
endpackage

// File: psa_alu.sv
// Packed SIMD integer ALU with its packed register file and aliased tag state
// Operation
// [RQ1] Exactly 47 packed operations in eight groups.
// [RQ2] 32-bit move copies low 32 bits between packed and memory or general registers.
// [RQ3] 64-bit move copies 64 bits between memory and packed, or packed to packed.
// [RQ4] Wraparound add/sub per byte, word or dword lane, dropping carries.
// [RQ5] Signed saturating add/sub on byte or word lanes clamps to signed range.
// [RQ6] Unsigned saturating add/sub on byte or word lanes clamps to unsigned range.
// [RQ7] Signed clamp gives 7FFF/8000 for words, 7F/80 for bytes.
// [RQ8] Unsigned clamp gives FF (FFFF) on overflow, 00 on underflow.
// [RQ9] Signed word multiply keeps high or low 16 bits of each product.
// [RQ10] Multiply-add sums low and high product pairs into two 32-bit results.
// [RQ11] Equal and signed greater compares write all-ones or all-zeros lanes.
// [RQ12] Compares leave the status flags register untouched.
// [RQ13] Signed pack narrows words or dwords with signed saturation.
// [RQ14] Unsigned pack narrows signed words to unsigned bytes with clamping.
// [RQ15] Unpack interleaves high or low halves of both operands.
// [RQ16] AND, AND-NOT, OR, XOR act bitwise on all 64 bits.
// [RQ17] AND-NOT inverts the destination operand, then ANDs with the source.
// [RQ18] Shifts move every element by one common count.
// [RQ19] Logical shifts on word, dword, qword fill with zeros.
// [RQ20] Arithmetic right shift on word, dword replicates the sign bit.
// [RQ21] Empty-state operation sets every tag to 11B.
// [RQ22] Software issues the empty-state operation before floating-point code.
// [RQ23] Every other operation sets the whole tag word to 00B.
// [RQ24] Writing a packed register sets bits 64 to 79 of its alias to ones.
// [RQ25] Eight 64-bit packed registers, readable and writable by every operation; empty_packed_state writes none.
`timescale 1ns/10ps
`default_nettype none
module psa_alu
   import psa_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   // Issue from decode
   input  wire logic        ISSUE_VALID,
   input  wire psa_op_t     ISSUE_OP,
   input  wire logic [2:0]  DEST_IDX,
   input  wire logic [2:0]  SRC_IDX,
   input  wire psa_src_t    SRC_SEL,
   input  wire logic        DEST_EXT,
   input  wire logic [63:0] EXT_DATA,
   // Result and side effects
   output logic             RESULT_VALID,
   output logic [63:0]      RESULT_DATA,
   output logic             FLAGS_WRITE,
   output logic [15:0]      TAG_WORD,
   // Aliased register read
   input  wire logic [2:0]  RD_IDX,
   output logic [79:0]      RD_DATA
);
   logic [63:0]        regs_r [NUM_REGS];
   logic [63:0]        regs_nxt [NUM_REGS];
   logic [15:0]        exp_r [NUM_REGS];
   logic [15:0]        exp_nxt [NUM_REGS];
   logic [15:0]        tag_r;
   logic [15:0]        tag_nxt;
   logic               valid_r;
   logic               valid_nxt;
   logic [63:0]        res_r;
   logic [63:0]        res_nxt;
   logic [79:0]        rd_r;
   logic [79:0]        rd_nxt;
   logic [63:0]        d_op;
   logic [63:0]        s_op;
   logic [63:0]        alu_res;
   logic [63:0]        mul_hi;
   logic [63:0]        mul_lo;
   logic [63:0]        madd;
   logic signed [31:0] prod [4];
   logic               wr_en;

   // Carry chain broken at lane edges; one adder serves all lane sizes
   function automatic logic [63:0] addsub_wrap(input logic [63:0] a, input logic [63:0] b,
                                               input logic sub, input logic [2:0] lb);
      logic [8:0]  t;
      logic        c;
      logic [63:0] r;
      c = 1'b0;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if ((i % int'(lb)) == 0) c = sub;
         t = {1'b0, a[8*i+:8]} + {1'b0, sub ? ~b[8*i+:8] : b[8*i+:8]} + {8'h00, c};
         r[8*i+:8] = t[7:0];
         c = t[8];
      end
      return r;
   endfunction

   function automatic logic [33:0] ext34(input logic [31:0] x, input logic [1:0] w,
                                         input logic uns);
      if (w == W_BYTE) return {{26{x[7] & ~uns}}, x[7:0]};
      else if (w == W_WORD) return {{18{x[15] & ~uns}}, x[15:0]};
      else return {{2{x[31] & ~uns}}, x};
   endfunction

   function automatic logic [15:0] clamp(input logic signed [33:0] v, input logic word,
                                         input logic uns);
      logic signed [33:0] hi;
      logic signed [33:0] lo;
      hi = uns ? (word ? UW_MAX : UB_MAX) : (word ? SW_MAX : SB_MAX); // see [RQ7] [RQ8]
      lo = uns ? U_MIN : (word ? SW_MIN : SB_MIN);
      if (v > hi) return hi[15:0];
      else if (v < lo) return lo[15:0];
      else return v[15:0];
   endfunction

   function automatic logic [63:0] sat_addsub(input logic [63:0] a, input logic [63:0] b,
                                              input logic sub, input logic word,
                                              input logic uns);
      logic signed [33:0] x;
      logic signed [33:0] y;
      logic [15:0]        q;
      logic [63:0]        r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if (word && i < 4) begin
            x = ext34({16'h0000, a[16*i+:16]}, W_WORD, uns);
            y = ext34({16'h0000, b[16*i+:16]}, W_WORD, uns);
            q = clamp(sub ? x - y : x + y, 1'b1, uns);
            r[16*i+:16] = q;
         end else if (!word) begin
            x = ext34({24'h00_0000, a[8*i+:8]}, W_BYTE, uns);
            y = ext34({24'h00_0000, b[8*i+:8]}, W_BYTE, uns);
            q = clamp(sub ? x - y : x + y, 1'b0, uns);
            r[8*i+:8] = q[7:0];
         end
      end
      return r;
   endfunction

   // Destination fills the low half, source the high half
   function automatic logic [63:0] pack(input logic [63:0] a, input logic [63:0] b,
                                        input logic dword, input logic uns);
      logic [15:0] q;
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         if (dword && i < 2) begin
            q = clamp(ext34(a[32*i+:32], W_DWORD, 1'b0), 1'b1, 1'b0);
            r[16*i+:16] = q;
            q = clamp(ext34(b[32*i+:32], W_DWORD, 1'b0), 1'b1, 1'b0);
            r[16*(i+2)+:16] = q;
         end else if (!dword) begin
            q = clamp(ext34({16'h0000, a[16*i+:16]}, W_WORD, 1'b0), 1'b0, uns);
            r[8*i+:8] = q[7:0];
            q = clamp(ext34({16'h0000, b[16*i+:16]}, W_WORD, 1'b0), 1'b0, uns);
            r[8*(i+4)+:8] = q[7:0];
         end
      end
      return r;
   endfunction

   function automatic logic [63:0] unpack(input logic [63:0] a, input logic [63:0] b,
                                          input logic hi, input logic [1:0] w);
      int          base;
      logic [63:0] r;
      base = hi ? HALF_BITS : 0;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         if (w == W_BYTE) begin
            r[16*i+:8] = a[base+8*i+:8];
            r[16*i+8+:8] = b[base+8*i+:8];
         end else if (w == W_WORD && i < 2) begin
            r[32*i+:16] = a[base+16*i+:16];
            r[32*i+16+:16] = b[base+16*i+:16];
         end
      end
      if (w == W_DWORD) r = {b[base+:32], a[base+:32]};
      return r;
   endfunction

   function automatic logic [63:0] compare(input logic [63:0] a, input logic [63:0] b,
                                           input logic gt, input logic [1:0] w);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if (w == W_BYTE)
            r[8*i+:8] = {8{gt ? $signed(a[8*i+:8]) > $signed(b[8*i+:8])
                              : a[8*i+:8] == b[8*i+:8]}};
         else if (w == W_WORD && i < 4)
            r[16*i+:16] = {16{gt ? $signed(a[16*i+:16]) > $signed(b[16*i+:16])
                                 : a[16*i+:16] == b[16*i+:16]}};
         else if (w == W_DWORD && i < 2)
            r[32*i+:32] = {32{gt ? $signed(a[32*i+:32]) > $signed(b[32*i+:32])
                                 : a[32*i+:32] == b[32*i+:32]}};
      end
      return r;
   endfunction

   // Counts past the lane width empty the lane, or fill it with sign
   function automatic logic [63:0] shift(input logic [63:0] a, input logic [63:0] cnt,
                                         input logic [1:0] w, input logic right,
                                         input logic arith);
      logic [6:0]  c;
      logic [63:0] r;
      c = (cnt > {57'h0_0000_0000_0000, SHIFT_LIMIT}) ? SHIFT_LIMIT : cnt[6:0];
      r = '0;
      for (int i = 0; i < 4; i++) begin
         if (w == W_WORD)
            r[16*i+:16] = right ? (arith ? 16'($signed(a[16*i+:16]) >>> c)
                                         : a[16*i+:16] >> c) : a[16*i+:16] << c;
         else if (w == W_DWORD && i < 2)
            r[32*i+:32] = right ? (arith ? 32'($signed(a[32*i+:32]) >>> c)
                                         : a[32*i+:32] >> c) : a[32*i+:32] << c;
      end
      if (w == W_QWORD) r = right ? a >> c : a << c;
      return r;
   endfunction

   // Operation datapath
   always_comb begin
      d_op = regs_r[DEST_IDX];                                               // see [RQ25]
      s_op = (SRC_SEL == src_packed) ? regs_r[SRC_IDX] : EXT_DATA;
      for (int i = 0; i < 4; i++) begin
         prod[i] = $signed(d_op[16*i+:16]) * $signed(s_op[16*i+:16]);
         mul_hi[16*i+:16] = prod[i][31:16];                                  // see [RQ9]
         mul_lo[16*i+:16] = prod[i][15:0];
      end
      madd = {32'(prod[3] + prod[2]), 32'(prod[1] + prod[0])};               // see [RQ10]
      unique case (ISSUE_OP)                                                 // see [RQ1]
         move_32:               alu_res = {32'h0000_0000, s_op[31:0]};      // see [RQ2]
         move_64:               alu_res = s_op;                              // see [RQ3]
         add_wrap_byte:         alu_res = addsub_wrap(d_op, s_op, 1'b0, LANE_BYTE); // see [RQ4]
         add_wrap_word:         alu_res = addsub_wrap(d_op, s_op, 1'b0, LANE_WORD);
         add_wrap_dword:        alu_res = addsub_wrap(d_op, s_op, 1'b0, LANE_DWORD);
         sub_wrap_byte:         alu_res = addsub_wrap(d_op, s_op, 1'b1, LANE_BYTE);
         sub_wrap_word:         alu_res = addsub_wrap(d_op, s_op, 1'b1, LANE_WORD);
         sub_wrap_dword:        alu_res = addsub_wrap(d_op, s_op, 1'b1, LANE_DWORD);
         add_sat_signed_byte:   alu_res = sat_addsub(d_op, s_op, 1'b0, 1'b0, 1'b0); // see [RQ5]
         add_sat_signed_word:   alu_res = sat_addsub(d_op, s_op, 1'b0, 1'b1, 1'b0);
         sub_sat_signed_byte:   alu_res = sat_addsub(d_op, s_op, 1'b1, 1'b0, 1'b0);
         sub_sat_signed_word:   alu_res = sat_addsub(d_op, s_op, 1'b1, 1'b1, 1'b0);
         add_sat_unsigned_byte: alu_res = sat_addsub(d_op, s_op, 1'b0, 1'b0, 1'b1); // see [RQ6]
         add_sat_unsigned_word: alu_res = sat_addsub(d_op, s_op, 1'b0, 1'b1, 1'b1);
         sub_sat_unsigned_byte: alu_res = sat_addsub(d_op, s_op, 1'b1, 1'b0, 1'b1);
         sub_sat_unsigned_word: alu_res = sat_addsub(d_op, s_op, 1'b1, 1'b1, 1'b1);
         mul_word_high_half:    alu_res = mul_hi;
         mul_word_low_half:     alu_res = mul_lo;
         mul_add_word_pairs:    alu_res = madd;
         cmp_equal_byte:        alu_res = compare(d_op, s_op, 1'b0, W_BYTE); // see [RQ11]
         cmp_equal_word:        alu_res = compare(d_op, s_op, 1'b0, W_WORD);
         cmp_equal_dword:       alu_res = compare(d_op, s_op, 1'b0, W_DWORD);
         cmp_greater_byte:      alu_res = compare(d_op, s_op, 1'b1, W_BYTE);
         cmp_greater_word:      alu_res = compare(d_op, s_op, 1'b1, W_WORD);
         cmp_greater_dword:     alu_res = compare(d_op, s_op, 1'b1, W_DWORD);
         pack_word_to_byte_signed:   alu_res = pack(d_op, s_op, 1'b0, 1'b0); // see [RQ13]
         pack_dword_to_word_signed:  alu_res = pack(d_op, s_op, 1'b1, 1'b0);
         pack_word_to_byte_unsigned: alu_res = pack(d_op, s_op, 1'b0, 1'b1); // see [RQ14]
         unpack_high_byte:      alu_res = unpack(d_op, s_op, 1'b1, W_BYTE);  // see [RQ15]
         unpack_high_word:      alu_res = unpack(d_op, s_op, 1'b1, W_WORD);
         unpack_high_dword:     alu_res = unpack(d_op, s_op, 1'b1, W_DWORD);
         unpack_low_byte:       alu_res = unpack(d_op, s_op, 1'b0, W_BYTE);
         unpack_low_word:       alu_res = unpack(d_op, s_op, 1'b0, W_WORD);
         unpack_low_dword:      alu_res = unpack(d_op, s_op, 1'b0, W_DWORD);
         bitwise_and_64:        alu_res = d_op & s_op;                      // see [RQ16]
         bitwise_and_not_64:    alu_res = ~d_op & s_op;                     // see [RQ17]
         bitwise_or_64:         alu_res = d_op | s_op;
         bitwise_xor_64:        alu_res = d_op ^ s_op;
         shl_logical_word:      alu_res = shift(d_op, s_op, W_WORD, 1'b0, 1'b0); // see [RQ18] [RQ19]
         shl_logical_dword:     alu_res = shift(d_op, s_op, W_DWORD, 1'b0, 1'b0);
         shl_logical_qword:     alu_res = shift(d_op, s_op, W_QWORD, 1'b0, 1'b0);
         shr_logical_word:      alu_res = shift(d_op, s_op, W_WORD, 1'b1, 1'b0);
         shr_logical_dword:     alu_res = shift(d_op, s_op, W_DWORD, 1'b1, 1'b0);
         shr_logical_qword:     alu_res = shift(d_op, s_op, W_QWORD, 1'b1, 1'b0);
         shr_arith_word:        alu_res = shift(d_op, s_op, W_WORD, 1'b1, 1'b1); // see [RQ20]
         shr_arith_dword:       alu_res = shift(d_op, s_op, W_DWORD, 1'b1, 1'b1);
         empty_packed_state:    alu_res = '0;
         default:               alu_res = '0;
      endcase
   end

   // Register file, alias and tag state
   always_comb begin
      wr_en = ISSUE_VALID && !DEST_EXT && ISSUE_OP != empty_packed_state;
      regs_nxt = regs_r;
      exp_nxt = exp_r;
      tag_nxt = tag_r;
      valid_nxt = ISSUE_VALID;
      res_nxt = ISSUE_VALID ? alu_res : res_r;
      if (ISSUE_VALID)
         tag_nxt = (ISSUE_OP == empty_packed_state) ? TAG_EMPTY : TAG_VALID; // see [RQ21] [RQ23]
      if (wr_en) begin
         regs_nxt[DEST_IDX] = alu_res;                                       // see [RQ25]
         exp_nxt[DEST_IDX] = EXP_ONES;                                       // see [RQ24]
      end
      rd_nxt = {exp_r[RD_IDX], regs_r[RD_IDX]};
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         regs_r <= '{default: REG_RST};
         exp_r <= '{default: EXP_RST};
         tag_r <= TAG_EMPTY;
         valid_r <= 1'b0;
         res_r <= REG_RST;
         rd_r <= {EXP_RST, REG_RST};
      end else begin
         regs_r <= regs_nxt;
         exp_r <= exp_nxt;
         tag_r <= tag_nxt;
         valid_r <= valid_nxt;
         res_r <= res_nxt;
         rd_r <= rd_nxt;
      end
   end

   // No operation here ever touches the status flags
   assign FLAGS_WRITE = 1'b0;                                                // see [RQ12]
   assign RESULT_VALID = valid_r;
   assign RESULT_DATA = res_r;
   assign TAG_WORD = tag_r;
   assign RD_DATA = rd_r;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_reg_write;
      ISSUE_VALID && !DEST_EXT && ISSUE_OP != empty_packed_state;
   endsequence
   sequence s_write_then_read;
      s_reg_write ##1 (RD_IDX == $past(DEST_IDX));
   endsequence

   a_tag_valid: assert property (ISSUE_VALID && ISSUE_OP != empty_packed_state // see [RQ23]
      |=> TAG_WORD == TAG_VALID) else $error("tag word not valid after op");
   a_tag_empty: assert property (ISSUE_VALID && ISSUE_OP == empty_packed_state // see [RQ21]
      |=> TAG_WORD == TAG_EMPTY) else $error("tag word not empty after empty op");
   a_alias_exp: assert property (s_write_then_read // see [RQ24]
      |=> RD_DATA[79:64] == EXP_ONES) else $error("alias exponent not ones");
   a_flags_hold: assert property (ISSUE_VALID && ISSUE_OP inside {[cmp_equal_byte:cmp_greater_dword]} // see [RQ12]
      |-> ##[0:1] !FLAGS_WRITE) else $error("compare wrote status flags");
   a_move_low: assert property (ISSUE_VALID && ISSUE_OP == move_32 // see [RQ2]
      |=> RESULT_DATA == {32'h0000_0000, $past(s_op[31:0])}) else $error("move_32 wrong");
   a_move_full: assert property (ISSUE_VALID && ISSUE_OP == move_64 // see [RQ3]
      |=> RESULT_VALID && RESULT_DATA == $past(s_op)) else $error("move_64 wrong");
   a_andn_order: assert property (ISSUE_VALID && ISSUE_OP == bitwise_and_not_64 // see [RQ17]
      |=> RESULT_DATA == (~$past(d_op) & $past(s_op))) else $error("and-not wrong");
   a_wrap_byte: assert property (ISSUE_VALID && ISSUE_OP == add_wrap_byte // see [RQ4]
      |=> RESULT_DATA[7:0] == 8'($past(d_op[7:0]) + $past(s_op[7:0]))) else $error("wrap add");
   a_sat_word: assert property (ISSUE_VALID && ISSUE_OP == add_sat_signed_word // see [RQ7]
      && d_op[15:0] == 16'h7FFF && !s_op[15] && s_op[15:0] != 16'h0000
      |=> RESULT_DATA[15:0] == 16'h7FFF) else $error("signed word clamp");
   a_sat_ubyte: assert property (ISSUE_VALID && ISSUE_OP == sub_sat_unsigned_byte // see [RQ8]
      && d_op[7:0] < s_op[7:0] |=> RESULT_DATA[7:0] == 8'h00) else $error("unsigned clamp");
   a_cmp_mask: assert property (ISSUE_VALID && ISSUE_OP == cmp_equal_byte && d_op == s_op // see [RQ11]
      |=> RESULT_DATA == 64'hFFFF_FFFF_FFFF_FFFF) else $error("equal mask wrong");
endmodule
`default_nettype wire

// File: psa_issue_model.sv
// Issue-side model of the decode stage that feeds the packed ALU
`timescale 1ns/10ps
`default_nettype none
module psa_issue_model
   import psa_pkg::*;
(
   // Clock
   input  wire logic   clk,
   // Issue bundle
   output logic        valid,
   output psa_op_t     op,
   output logic [2:0]  dest,
   output logic [2:0]  src,
   output psa_src_t    sel,
   output logic        ext,
   output logic [63:0] data
);
   initial begin
      valid = 1'b0;
      op = empty_packed_state;
      dest = 3'h0;
      src = 3'h0;
      sel = src_packed;
      ext = 1'b0;
      data = 64'h0;
   end
   // Drive just after an edge and hold across the taking edge; the ALU has no backpressure
   task automatic issue(input psa_op_t o, input logic [2:0] d, input logic [2:0] s,
                        input psa_src_t sl, input logic e, input logic [63:0] x);
      valid = 1'b1;
      op = o;
      dest = d;
      src = s;
      sel = sl;
      ext = e;
      data = x;
      @(posedge clk);
      #1;
   endtask
   // An unused operand bus must not keep a stale value, so idle cycles scramble it
   task automatic idle();
      valid = 1'b0;
      data = ~data;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: packed_simd_integer_alu_tb.sv
// Self-checking bench for the packed SIMD integer ALU
`timescale 1ns/10ps
`default_nettype none
module packed_simd_integer_alu_tb;
   import psa_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  rd_idx = 3'h0;
   logic [2:0]  last_d = 3'h0;
   wire logic   iv, ie, rv, fw;
   wire psa_op_t iop;
   wire psa_src_t isel;
   wire logic [2:0] idst, isrc;
   wire logic [63:0] ix, rdat;
   wire logic [15:0] tag;
   wire logic [79:0] rd_data;
   logic [63:0] shadow [8];
   logic [15:0] exp_sh [8];
   logic [63:0] corner [6] = '{64'h7FFF_807F_0080_FF01, 64'h8000_7FFF_FF7F_0180,
      64'hFFFF_FFFF_8000_0000, 64'h0000_0000_7FFF_FFFF, 64'h10, 64'h20};
   int n_mismatch = 0;
   int checks_done = 0;
   always #20 clk_sys = ~clk_sys;
   psa_issue_model model_u (.clk(clk_sys), .valid(iv), .op(iop), .dest(idst), .src(isrc),
      .sel(isel), .ext(ie), .data(ix));
   psa_alu dut_u (.CLK_SYS(clk_sys), .RST(rst), .ISSUE_VALID(iv), .ISSUE_OP(iop),
      .DEST_IDX(idst), .SRC_IDX(isrc), .SRC_SEL(isel), .DEST_EXT(ie), .EXT_DATA(ix),
      .RESULT_VALID(rv), .RESULT_DATA(rdat), .FLAGS_WRITE(fw), .TAG_WORD(tag),
      .RD_IDX(rd_idx), .RD_DATA(rd_data));
   task automatic chk(input logic [79:0] got, input logic [79:0] want, input string what);
      checks_done++;
      if (got !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask
   function automatic longint lane(input logic [63:0] x, input int i, input int w, input bit sg);
      logic [63:0] m, v;
      m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
      v = (x >> (i * w)) & m;
      if (sg && v[w - 1]) v = v | ~m;
      return longint'(v);
   endfunction
   function automatic longint clip(input longint v, input longint lo, input longint h);
      return (v < lo) ? lo : ((v > h) ? h : v);
   endfunction
   function automatic int lw(input psa_op_t o);
      if (o inside {add_wrap_byte, sub_wrap_byte, add_sat_signed_byte, sub_sat_signed_byte,
         add_sat_unsigned_byte, sub_sat_unsigned_byte, cmp_equal_byte, cmp_greater_byte,
         unpack_high_byte, unpack_low_byte, pack_word_to_byte_signed,
         pack_word_to_byte_unsigned}) return 8;
      if (o inside {add_wrap_dword, sub_wrap_dword, cmp_equal_dword, cmp_greater_dword,
         unpack_high_dword, unpack_low_dword, shl_logical_dword, shr_logical_dword,
         shr_arith_dword, mul_add_word_pairs}) return 32;
      if (o inside {shl_logical_qword, shr_logical_qword}) return 64;
      return 16;
   endfunction
   function automatic logic [63:0] ref_op(input psa_op_t o, input logic [63:0] d,
                                          input logic [63:0] s);
      logic [63:0] r, m;
      longint a, b, ua, ub, v, hi;
      int w, n;
      w = lw(o);
      n = 64 / w;
      m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
      hi = (64'sh1 <<< (w - 1)) - 1;
      r = 64'h0;
      v = 0;
      case (o)
         move_32: return {32'h0, s[31:0]};
         move_64: return s;
         bitwise_and_64: return d & s;
         bitwise_and_not_64: return ~d & s;
         bitwise_or_64: return d | s;
         bitwise_xor_64: return d ^ s;
         empty_packed_state: return 64'h0;
         default: ;
      endcase
      for (int i = 0; i < n; i++) begin
         a = lane(d, i, w, 1);
         b = lane(s, i, w, 1);
         ua = lane(d, i, w, 0);
         ub = lane(s, i, w, 0);
         case (o)
            add_wrap_byte, add_wrap_word, add_wrap_dword: v = a + b;
            sub_wrap_byte, sub_wrap_word, sub_wrap_dword: v = a - b;
            add_sat_signed_byte, add_sat_signed_word: v = clip(a + b, -hi - 1, hi);
            sub_sat_signed_byte, sub_sat_signed_word: v = clip(a - b, -hi - 1, hi);
            add_sat_unsigned_byte, add_sat_unsigned_word: v = clip(ua + ub, 0, hi * 2 + 1);
            sub_sat_unsigned_byte, sub_sat_unsigned_word: v = clip(ua - ub, 0, hi * 2 + 1);
            mul_word_high_half: v = (a * b) >>> 16;
            mul_word_low_half: v = a * b;
            mul_add_word_pairs: v = lane(d, 2 * i, 16, 1) * lane(s, 2 * i, 16, 1)
               + lane(d, 2 * i + 1, 16, 1) * lane(s, 2 * i + 1, 16, 1);
            cmp_equal_byte, cmp_equal_word, cmp_equal_dword: v = (a == b) ? -1 : 0;
            cmp_greater_byte, cmp_greater_word, cmp_greater_dword: v = (a > b) ? -1 : 0;
            pack_word_to_byte_signed, pack_dword_to_word_signed:
               v = clip(lane((i < n / 2) ? d : s, i % (n / 2), 2 * w, 1), -hi - 1, hi);
            pack_word_to_byte_unsigned:
               v = clip(lane((i < n / 2) ? d : s, i % (n / 2), 16, 1), 0, hi * 2 + 1);
            unpack_low_byte, unpack_low_word, unpack_low_dword:
               v = lane((i % 2) ? s : d, i / 2, w, 0);
            unpack_high_byte, unpack_high_word, unpack_high_dword:
               v = lane((i % 2) ? s : d, i / 2 + n / 2, w, 0);
            shl_logical_word, shl_logical_dword, shl_logical_qword: v = (s >= w) ? 0 : ua << s;
            shr_logical_word, shr_logical_dword, shr_logical_qword: v = (s >= w) ? 0 : ua >> s;
            default: v = a >>> ((s >= w) ? w - 1 : s);
         endcase
         r = r | ((64'(v) & m) << (i * w));
      end
      return r;
   endfunction
   task automatic do_op(input psa_op_t o, input logic [2:0] d, input logic [2:0] s,
                        input psa_src_t sl, input logic e, input logic [63:0] x);
      logic [63:0] want;
      want = ref_op(o, shadow[d], (sl == src_packed) ? shadow[s] : x);
      rd_idx = last_d;
      model_u.issue(o, d, s, sl, e, x);
      chk(80'(rv), 80'h1, "result valid");
      chk(80'(rdat), 80'(want), o.name());
      chk(80'(tag), 80'((o == empty_packed_state) ? TAG_EMPTY : TAG_VALID), "tag");
      chk(80'(fw), 80'h0, "flags");
      chk(rd_data, {exp_sh[last_d], shadow[last_d]}, "alias read");
      if (!e && o != empty_packed_state) begin
         shadow[d] = want;
         exp_sh[d] = 16'hFFFF;
      end
      last_d = d;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      psa_op_t o;
      logic [63:0] x;
      void'($urandom(32'h8ccacf81));
      foreach (shadow[i]) shadow[i] = 64'h0;
      foreach (exp_sh[i]) exp_sh[i] = 16'h0;
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      chk(80'(tag), 80'(TAG_EMPTY), "reset tag");
      chk(80'(rv), 80'h0, "reset valid");
      for (int r = 0; r < 8; r++)
         do_op(move_64, 3'(r), 3'h0, src_memory, 1'b0, {$urandom, $urandom});
      for (int k = 0; k < 47 * 12; k++) begin
         o = psa_op_t'(6'(k % 47));
         x = (k < 47 * 4) ? corner[$urandom_range(5)] : {$urandom, $urandom};
         if (o inside {[shl_logical_word:shr_arith_dword]} && k[0]) x = 64'($urandom_range(70));
         if (k < 47 * 4) do_op(move_64, 3'(k), 3'h0, src_memory, 1'b0, corner[$urandom_range(5)]);
         do_op(o, 3'($urandom), 3'($urandom), (k < 47 * 4) ? src_memory : psa_src_t'($urandom_range(2)),
            ($urandom_range(3) == 0), x);
         if ($urandom_range(4) == 0) begin
            model_u.idle();
            chk(80'(rv), 80'h0, "pulse");
         end
      end
      // Hand corners: positive word overflow, and a register compared with itself
      do_op(move_64, 3'h2, 3'h0, src_memory, 1'b0, 64'h0000_0000_0000_7FFF);
      do_op(add_sat_signed_word, 3'h2, 3'h0, src_memory, 1'b0, 64'h0000_0000_0000_0001);
      do_op(cmp_equal_byte, 3'h1, 3'h1, src_packed, 1'b0, 64'h0);
      do_op(empty_packed_state, 3'h0, 3'h0, src_packed, 1'b0, 64'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
